// File: hdl/psa_pkg.sv
/*
  Package for the status and alarm block: command codes, status layout,
  request and pin bundles, sizes and timing figures.
  Assumes a single 100 MHz clock domain in the using module.
*/
package psa_pkg;

  // Command codes seen on the request port
  localparam logic [7:0] PSA_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] PSA_CMD_STATUS_BYTE  = 8'h78;
  localparam logic [7:0] PSA_CMD_FAN_SPEED    = 8'hD7;
  localparam logic [7:0] PSA_CMD_HOST_NVM     = 8'hE0;
  localparam logic [7:0] PSA_CMD_CUST_NVM     = 8'hE1;

  // Answer to any invalid or unsupported read
  localparam logic [7:0] PSA_INVALID_DATA     = 8'h00;

  // Serial-number field
  localparam int unsigned PSA_SERIAL_LEN      = 15;
  localparam logic [7:0]  PSA_SPACE_CHAR      = 8'h20;

  // Nonvolatile storage sizes in bytes
  localparam int unsigned PSA_HOST_NVM_BYTES  = 96;
  localparam int unsigned PSA_CUST_NVM_BYTES  = 128;
  localparam int unsigned PSA_NVM_ADDR_W      = 7;

  // Fan demand in percent of duty; full duty is the top fan speed
  localparam logic [6:0]  PSA_FAN_FULL_PCT    = 7'h64;
  localparam int unsigned PSA_FAN_MAX_RPM     = 16000;
  localparam logic [6:0]  PSA_PWM_LAST        = 7'h63;

  // Status byte bit positions
  localparam int unsigned PSA_ST_OV_BIT       = 0;
  localparam int unsigned PSA_ST_OC_BIT       = 1;
  localparam int unsigned PSA_ST_OT_BIT       = 2;
  localparam int unsigned PSA_ST_INLOW_BIT    = 3;
  localparam int unsigned PSA_ST_CML_BIT      = 4;
  localparam int unsigned PSA_ST_W            = 5;

  // Fault pins from the power stage
  typedef struct packed {
    logic input_low;
    logic over_temp;
    logic over_current;
    logic overvoltage_protection;
  } psa_fault_t;

  // One request from the management bus front end
  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic [7:0]                code;
    logic [PSA_NVM_ADDR_W-1:0] addr;
    logic [7:0]                data;
  } psa_req_t;

  // Front-panel lamps
  typedef struct packed {
    logic input_green;
    logic output_green;
    logic fault_lamp_red;
  } psa_lamp_t;

  // Active-high monitoring outputs
  typedef struct packed {
    logic fault_n;
    logic output_good;
    logic input_good;
    logic temp_good;
  } psa_mon_t;

endpackage : psa_pkg

// File: hdl/psa_status_alarm.sv
/*
  Status and alarm logic of the converter management controller: command
  checking and zero answers for invalid reads, sticky status with the alert
  line, clear-faults, lamps and monitoring outputs, serial-number padding,
  fan demand with duty generator, host and customer byte storage.
  Assumes a bus front end that hands over decoded requests on clk_i, and
  fault and write-protect pins that are asynchronous to clk_i.
  // Function
  // RULE_01: Unsupported command or bad data sets status bits and asserts the alert.
  // RULE_02: Reads of invalid or unsupported commands answer with a zero byte.
  // RULE_03: Unused trailing serial-number positions are filled with space characters.
  // RULE_04: Normal operation: both good lamps green, fault lamp off, monitors high.
  // RULE_05: Any fault condition lights the fault lamp red.
  // RULE_06: Output faults: input lamp green, output lamp off, temp-good low only for heat.
  // RULE_07: Low input: both good lamps off, fault red, temp-good stays high.
  // RULE_08: Fan demand spans zero to full duty, full meaning top fan speed.
  // RULE_09: Fan runs at the lowest speed the present conditions require.
  // RULE_10: Ninety-six bytes of storage are offered to the host.
  // RULE_11: Separate 128-byte customer storage whose writes are blocked under write protect.
  // RULE_12: Clear-faults empties status and releases alert; persisting faults set again.
  // RULE_13: Alert stays asserted until the master clears the faults.
*/
module psa_status_alarm
  import psa_pkg::*;
#(
  parameter int unsigned SERIAL_LEN = PSA_SERIAL_LEN,
  parameter int unsigned HOST_BYTES = PSA_HOST_NVM_BYTES,
  parameter int unsigned CUST_BYTES = PSA_CUST_NVM_BYTES
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,

  // Requests from the management bus front end
  input  wire psa_req_t                     req_i,
  output logic                              rsp_valid_o,
  output logic [7:0]                        rsp_data_o,

  // Asynchronous pins
  input  wire psa_fault_t                   fault_pins_i,
  input  wire logic                         write_protect_i,

  // Serial number as stored, with its used length
  input  wire logic [SERIAL_LEN-1:0][7:0]   serial_chars_i,
  input  wire logic [3:0]                   serial_used_i,

  // Least fan duty the thermal conditions need, percent
  input  wire logic [6:0]                   fan_required_i,

  // Status and alert
  output logic [PSA_ST_W-1:0]               status_o,
  output logic                              smbalert_n_o,

  // Lamps and monitors
  output psa_lamp_t                         lamp_o,
  output psa_mon_t                          mon_o,

  // Serial-number field as presented
  output logic [SERIAL_LEN-1:0][7:0]        serial_field_o,

  // Fan demand and drive
  output logic [6:0]                        fan_duty_o,
  output logic                              fan_pwm_o
);

  localparam int unsigned PIN_W = $bits(psa_fault_t) + 1;

  // Command acceptance table
  function automatic logic cmd_ok(input logic [7:0] code, input logic wr);
    case (code)
      PSA_CMD_CLEAR_FAULTS: cmd_ok = wr;
      PSA_CMD_STATUS_BYTE:  cmd_ok = !wr;
      PSA_CMD_FAN_SPEED:    cmd_ok = 1'b1;
      PSA_CMD_HOST_NVM:     cmd_ok = 1'b1;
      PSA_CMD_CUST_NVM:     cmd_ok = 1'b1;
      default:              cmd_ok = 1'b0;
    endcase
  endfunction

  // Accepted write of one command code
  function automatic logic write_of(input psa_req_t req, input logic ok, input logic [7:0] code);
    write_of = req.valid && ok && req.write && (req.code == code);
  endfunction

  // Pin synchronisers
  // Pins start low after reset, so no false fault follows it
  logic [PIN_W-1:0] sync1_reg, sync1_next;
  logic [PIN_W-1:0] sync2_reg, sync2_next;
  logic [PIN_W-1:0] sync3_reg, sync3_next;
  logic [PIN_W-1:0] pins_reg,  pins_next;

  always_comb begin
    sync1_next = {write_protect_i, fault_pins_i};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    // A change counts once the second and third stages agree
    pins_next  = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pins_reg & (sync2_reg ^ sync3_reg));
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pins_reg  <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      pins_reg  <= pins_next;
    end
  end

  psa_fault_t faults;
  logic       wp_active;
  logic       any_fault;
  logic       output_fault;

  assign faults       = psa_fault_t'(pins_reg[PIN_W-2:0]);
  assign wp_active    = pins_reg[PIN_W-1];
  assign output_fault = faults.overvoltage_protection | faults.over_current | faults.over_temp;
  assign any_fault    = output_fault | faults.input_low;

  // Request decode
  logic       req_ok;
  logic       data_bad;
  logic       cml_event;
  logic       clear_cmd;
  logic       host_sel;
  logic       cust_sel;

  always_comb begin
    req_ok    = cmd_ok(req_i.code, req_i.write);
    host_sel  = req_i.valid && req_ok && (req_i.code == PSA_CMD_HOST_NVM);
    cust_sel  = req_i.valid && req_ok && (req_i.code == PSA_CMD_CUST_NVM);
    data_bad  = 1'b0;
    if (write_of(req_i, req_ok, PSA_CMD_FAN_SPEED)) begin
      data_bad = (req_i.data > PSA_FAN_FULL_PCT);
    end
    // Out-of-range storage address counts as bad data
    if (host_sel && (32'(req_i.addr) >= HOST_BYTES)) begin
      data_bad = 1'b1;
    end
    if (cust_sel && (32'(req_i.addr) >= CUST_BYTES)) begin
      data_bad = 1'b1;
    end
    cml_event = req_i.valid && (!req_ok || data_bad);  // see RULE_01
    clear_cmd = write_of(req_i, req_ok, PSA_CMD_CLEAR_FAULTS);
  end

  // Byte storage, no reset: contents stand until overwritten
  logic [7:0] host_mem [HOST_BYTES];  // see RULE_10
  logic [7:0] cust_mem [CUST_BYTES];  // see RULE_11
  logic       host_we;
  logic       cust_we;

  assign host_we = host_sel && req_i.write && !data_bad;
  // Write protect drops the write quietly, with no command error
  assign cust_we = cust_sel && req_i.write && !data_bad && !wp_active;  // see RULE_11

  always_ff @(posedge clk_i) begin
    if (host_we) begin
      host_mem[req_i.addr] <= req_i.data;
    end
    if (cust_we) begin
      cust_mem[req_i.addr] <= req_i.data;
    end
  end

  // Status, alert, fan demand, answers
  logic [PSA_ST_W-1:0] status_reg, status_next;
  logic [PSA_ST_W-1:0] status_set;
  logic                alert_n_reg, alert_n_next;
  logic [6:0]          host_fan_reg, host_fan_next;
  logic                rsp_valid_reg, rsp_valid_next;
  logic [7:0]          rsp_data_reg, rsp_data_next;
  logic [6:0]          fan_duty_reg, fan_duty_next;

  always_comb begin
    status_set                   = '0;
    status_set[PSA_ST_OV_BIT]    = faults.overvoltage_protection;
    status_set[PSA_ST_OC_BIT]    = faults.over_current;
    status_set[PSA_ST_OT_BIT]    = faults.over_temp;
    status_set[PSA_ST_INLOW_BIT] = faults.input_low;
    status_set[PSA_ST_CML_BIT]   = cml_event;  // see RULE_01
    // Clear empties all bits; a persisting or new event sets again, set wins
    status_next  = (clear_cmd ? '0 : status_reg) | status_set;  // see RULE_12
    // Alert held as long as any sticky bit stands
    alert_n_next = ~(|status_next);  // see RULE_13

    // Accepted fan writes become the host's demand
    host_fan_next = host_fan_reg;
    if (write_of(req_i, req_ok, PSA_CMD_FAN_SPEED) && !data_bad) begin
      host_fan_next = req_i.data[6:0];
    end

    rsp_valid_next = req_i.valid && !req_i.write;
    rsp_data_next  = PSA_INVALID_DATA;  // see RULE_02
    if (req_i.valid && !req_i.write && req_ok && !data_bad) begin
      case (req_i.code)
        PSA_CMD_STATUS_BYTE: rsp_data_next = 8'({status_reg});
        PSA_CMD_FAN_SPEED:   rsp_data_next = {1'b0, fan_duty_reg};
        PSA_CMD_HOST_NVM:    rsp_data_next = host_mem[req_i.addr];
        PSA_CMD_CUST_NVM:    rsp_data_next = cust_mem[req_i.addr];
        default:             rsp_data_next = PSA_INVALID_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_reg    <= '0;
      alert_n_reg   <= 1'b1;
      host_fan_reg  <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= PSA_INVALID_DATA;
    end else begin
      status_reg    <= status_next;
      alert_n_reg   <= alert_n_next;
      host_fan_reg  <= host_fan_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
    end
  end

  // Fan duty
  logic [6:0] fan_need;
  logic [6:0] pwm_cnt_reg, pwm_cnt_next;
  logic       pwm_reg, pwm_next;

  always_comb begin
    // Thermal need clamped to full duty
    fan_need = (fan_required_i > PSA_FAN_FULL_PCT) ? PSA_FAN_FULL_PCT : fan_required_i;  // see RULE_08
    // Host may raise speed but never below what the unit needs
    fan_duty_next = (host_fan_reg > fan_need) ? host_fan_reg : fan_need;  // see RULE_09
    // Counter wraps after one hundred steps, one drive period
    pwm_cnt_next  = (pwm_cnt_reg == PSA_PWM_LAST) ? 7'h00 : pwm_cnt_reg + 7'h01;
    // Full duty keeps the drive high for the whole period
    pwm_next      = (pwm_cnt_next < fan_duty_reg);  // see RULE_08
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fan_duty_reg  <= '0;
      pwm_cnt_reg   <= '0;
      pwm_reg       <= 1'b0;
    end else begin
      fan_duty_reg  <= fan_duty_next;
      pwm_cnt_reg   <= pwm_cnt_next;
      pwm_reg       <= pwm_next;
    end
  end

  // Lamps, monitors, serial field
  psa_lamp_t                  lamp_reg, lamp_next;
  psa_mon_t                   mon_reg, mon_next;
  logic [SERIAL_LEN-1:0][7:0] serial_reg, serial_next;
  logic [SERIAL_LEN-1:0][7:0] serial_pad;

  // Space padding beyond the used length
  for (genvar g = 0; g < SERIAL_LEN; g++) begin : g_pad
    assign serial_pad[g] = (g < int'(serial_used_i)) ? serial_chars_i[g] : PSA_SPACE_CHAR;  // see RULE_03
  end

  always_comb begin
    // Lamps and monitors follow the filtered pins, no latching
    lamp_next.input_green    = !faults.input_low;               // see RULE_07
    lamp_next.output_green   = !any_fault;                      // see RULE_06
    lamp_next.fault_lamp_red = any_fault;                       // see RULE_05
    mon_next.fault_n         = !any_fault;                      // see RULE_04
    mon_next.output_good     = !any_fault;                      // see RULE_06
    mon_next.input_good      = !faults.input_low;               // see RULE_07
    mon_next.temp_good       = !faults.over_temp;               // see RULE_06
    serial_next              = serial_pad;                      // see RULE_03
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lamp_reg      <= '0;
      mon_reg       <= '0;
      serial_reg    <= '0;
    end else begin
      lamp_reg      <= lamp_next;
      mon_reg       <= mon_next;
      serial_reg    <= serial_next;
    end
  end

  // Outputs straight from their registers
  assign status_o       = status_reg;
  assign smbalert_n_o   = alert_n_reg;
  assign rsp_valid_o    = rsp_valid_reg;
  assign rsp_data_o     = rsp_data_reg;
  assign lamp_o         = lamp_reg;
  assign mon_o          = mon_reg;
  assign serial_field_o = serial_reg;
  assign fan_duty_o     = fan_duty_reg;
  assign fan_pwm_o      = pwm_reg;

endmodule // psa_status_alarm

// File: sim/psa_host_model.sv
/*
  Management bus host: issues one decoded request at a time.
  Assumes read answers are registered on the taking edge itself.
*/
module psa_host_model
  import psa_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Request and answer
  output psa_req_t        req_o,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_i) #1 req_o = {1'b1, w, c, a, d};
    @(posedge clk_i) #1 req_o = {1'b0, ~w, ~c, ~a, ~d};
    // Released lines show no stale value; a missing answer reads unknown
    q = rsp_valid_i ? rsp_data_i : 8'hXX;
  endtask
endmodule // psa_host_model

// File: sim/psa_status_alarm_chk.sv
/*
  Port checker of the status and alarm block.
  Bound to every instance of the block; one clock domain.
*/
module psa_status_alarm_chk
  import psa_pkg::*;
#(parameter int unsigned SERIAL_LEN = 15) (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire psa_req_t                   req_i,
  input wire logic                       rsp_valid_o,
  input wire logic [7:0]                 rsp_data_o,
  input wire psa_fault_t                 fault_pins_i,
  input wire logic                       write_protect_i,
  input wire logic [SERIAL_LEN-1:0][7:0] serial_chars_i,
  input wire logic [3:0]                 serial_used_i,
  input wire logic [6:0]                 fan_required_i,
  input wire logic [PSA_ST_W-1:0]        status_o,
  input wire logic                       smbalert_n_o,
  input wire psa_lamp_t                  lamp_o,
  input wire psa_mon_t                   mon_o,
  input wire logic [SERIAL_LEN-1:0][7:0] serial_field_o,
  input wire logic [6:0]                 fan_duty_o,
  input wire logic                       fan_pwm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bad;
  logic clr;
  assign bad = req_i.valid && !(req_i.code inside {8'h03, 8'h78, 8'hD7, 8'hE0, 8'hE1});
  assign clr = req_i.valid && req_i.write && req_i.code == 8'h03;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_clr; clr; endsequence
  sequence s_full2; fan_duty_o == 7'h64 ##1 fan_duty_o == 7'h64; endsequence
  cml_alert_a: assert property (bad |=> status_o[4] && !smbalert_n_o) else $error("cml not flagged");
  bad_read_a: assert property (bad && !req_i.write |=> rsp_valid_o && rsp_data_o == 8'h00)
    else $error("bad read not zero");
  alert_hold_a: assert property (!smbalert_n_o && !clr |=> !smbalert_n_o) else $error("alert dropped");
  alert_track_a: assert property (smbalert_n_o == (status_o == 5'h00)) else $error("alert vs status");
  clear_cml_a: assert property (s_clr |=> !status_o[4]) else $error("clear ignored");
  normal_lamps_a: assert property (fault_pins_i == 4'h0 [*8] |-> lamp_o == 3'h6 && mon_o == 4'hF)
    else $error("normal lamps");
  out_flt_a: assert property ((fault_pins_i == 4'h1 || fault_pins_i == 4'h2) [*8]
    |-> lamp_o == 3'h5 && mon_o == 4'h3) else $error("ov oc lamps");
  hot_flt_a: assert property (fault_pins_i == 4'h4 [*8] |-> lamp_o == 3'h5 && mon_o == 4'h2)
    else $error("ot lamps");
  in_low_a: assert property (fault_pins_i == 4'h8 [*8] |-> lamp_o == 3'h1 && mon_o == 4'h1)
    else $error("input low lamps");
  fan_floor_a: assert property (fan_duty_o <= 7'h64 && fan_duty_o >= ($past(fan_required_i) > 7'h64 ? 7'h64 :
    $past(fan_required_i))) else $error("fan duty range");
  pwm_full_a: assert property (s_full2 |-> fan_pwm_o) else $error("full duty pwm low");
endmodule // psa_status_alarm_chk
bind psa_status_alarm psa_status_alarm_chk #(.SERIAL_LEN(SERIAL_LEN)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .fault_pins_i(fault_pins_i), .write_protect_i(write_protect_i), .serial_chars_i(serial_chars_i),
  .serial_used_i(serial_used_i), .fan_required_i(fan_required_i), .status_o(status_o),
  .smbalert_n_o(smbalert_n_o), .lamp_o(lamp_o), .mon_o(mon_o), .serial_field_o(serial_field_o),
  .fan_duty_o(fan_duty_o), .fan_pwm_o(fan_pwm_o)
);

// File: sim/tb_psa_status_alarm.sv
/*
  Testbench of the status and alarm block with a host model.
  Assumes the block's package and the checker are compiled first.
*/
module tb_psa_status_alarm import psa_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, sys_rst_i, rsp_valid_o, write_protect_i, smbalert_n_o, fan_pwm_o;
  psa_req_t req_i;
  psa_fault_t fault_pins_i;
  psa_lamp_t lamp_o;
  psa_mon_t mon_o;
  logic [7:0] rsp_data_o, q;
  logic [14:0][7:0] serial_chars_i, serial_field_o;
  logic [3:0] serial_used_i;
  logic [6:0] fan_required_i, fan_duty_o;
  logic [4:0] status_o;
  int failures = 0, samples_checked = 0, cycles = 0;
  psa_host_model i_host (.clk_i(clk_i), .req_o(req_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));
  psa_status_alarm i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .fault_pins_i(fault_pins_i), .write_protect_i(write_protect_i), .serial_chars_i(serial_chars_i),
    .serial_used_i(serial_used_i), .fan_required_i(fan_required_i), .status_o(status_o),
    .smbalert_n_o(smbalert_n_o), .lamp_o(lamp_o), .mon_o(mon_o), .serial_field_o(serial_field_o),
    .fan_duty_o(fan_duty_o), .fan_pwm_o(fan_pwm_o)
  );
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i) #1;
  endtask
  task automatic go(input logic wr, input logic [7:0] c, input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(wr, c, a, d, q);
  endtask
  task automatic t_lamps;
    logic [3:0] p [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [6:0] e [5] = '{7'h6F, 7'h53, 7'h53, 7'h52, 7'h11};
    for (int i = 0; i < 5; i++) begin
      fault_pins_i = p[i];
      w(10);
      chk({lamp_o, mon_o}, e[i]);
    end
    fault_pins_i = 4'h4;
    w(10);
    go(1, 8'h03, 0, 0);
    w(2);
    chk({status_o, smbalert_n_o}, 6'h08);
    fault_pins_i = 4'h0;
    w(10);
    go(1, 8'h03, 0, 0);
    w(2);
    chk({status_o, smbalert_n_o}, 6'h01);
    $display("lamps done");
  endtask
  task automatic t_cmd;
    go(0, 8'h55, 0, 0);
    chk(q, 8'h00);
    w(20);
    chk({status_o, smbalert_n_o}, 6'h20);
    go(0, 8'h78, 0, 0);
    chk(q, 8'h10);
    go(1, 8'h03, 0, 0);
    w(1);
    chk({status_o, smbalert_n_o}, 6'h01);
    go(1, 8'hD7, 0, 8'h65);
    w(1);
    chk({status_o, smbalert_n_o}, 6'h20);
    go(1, 8'h03, 0, 0);
    $display("commands done");
  endtask
  task automatic t_fan;
    int n;
    fan_required_i = 7'h10;
    go(1, 8'hD7, 0, 8'h32);
    w(3);
    chk(fan_duty_o, 7'h32);
    go(0, 8'hD7, 0, 0);
    chk(q, 8'h32);
    n = 0;
    repeat (100) begin
      w(1);
      n += fan_pwm_o;
    end
    chk(n[15:0], 16'h0032);
    fan_required_i = 7'h50;
    w(3);
    chk(fan_duty_o, 7'h50);
    fan_required_i = 7'h7F;
    w(3);
    chk(fan_duty_o, 7'h64);
    go(1, 8'hD7, 0, 8'h00);
    fan_required_i = 7'h00;
    w(3);
    chk(fan_duty_o, 7'h00);
    $display("fan done");
  endtask
  task automatic t_nvm;
    go(1, 8'hE0, 7'h5F, 8'hA5);
    go(0, 8'hE0, 7'h5F, 0);
    chk(q, 8'hA5);
    go(0, 8'hE0, 7'h60, 0);
    chk({q, status_o}, 13'h0010);
    go(1, 8'h03, 0, 0);
    go(1, 8'hE1, 7'h7F, 8'h5A);
    write_protect_i = 1;
    w(6);
    go(1, 8'hE1, 7'h7F, 8'h3C);
    go(0, 8'hE1, 7'h7F, 0);
    chk({q, status_o}, 13'h0B40);
    write_protect_i = 0;
    $display("storage done");
  endtask
  task automatic t_serial;
    for (int i = 0; i < 15; i++) serial_chars_i[i] = 8'h30 + i[7:0];
    serial_used_i = 4'h4;
    w(3);
    for (int i = 0; i < 15; i++) chk(serial_field_o[i], i < 4 ? 8'h30 + i[7:0] : 8'h20);
    $display("serial done");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {fault_pins_i, write_protect_i, serial_chars_i, serial_used_i, fan_required_i} = '0;
    sys_rst_i = 1;
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 0;
    t_lamps();
    t_cmd();
    t_fan();
    t_nvm();
    t_serial();
    wrap_up();
  end
endmodule // tb_psa_status_alarm
